// File: rtl/sam_decoder.sv
// Purpose: system address map decoder with trap and request control
// Assumes: access address is valid with acc_req, same clock domain
// Notes: one registered route per accepted access
`timescale 1ns/1ps
module sam_decoder (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic acc_req,
    input wire logic [23:0] acc_addr,
    input wire logic [sam_pkg::TRAP_W-1:0] hw_trap,
    input wire logic [sam_pkg::TRAP_W-1:0] trap_clr,
    input wire logic trap_done,
    input wire logic [sam_pkg::IRQ_W-1:0] hw_irq,
    input wire logic sw_req_we,
    input wire logic [sam_pkg::IRQ_IDX_W-1:0] sw_req_idx,
    input wire logic std_irq_in,
    input wire logic pec_req_in,
    output sam_pkg::sam_route_s route_q,
    output logic route_valid_q,
    output logic [19:0] region_sel_q,
    output logic [sam_pkg::TRAP_W-1:0] trap_flags,
    output logic trap_take,
    output logic [2:0] trap_level_q,
    output logic trap_active_q,
    output logic [sam_pkg::IRQ_W-1:0] irq_req_q,
    output logic std_irq_grant,
    output logic pec_grant
);
    logic rst_m_q;
    logic rst_s_q;
    sam_pkg::sam_route_s route_d;
    logic [sam_pkg::TRAP_W-1:0] trap_set;
    logic [sam_pkg::TRAP_W-1:0] pend;
    logic [2:0] top_idx;

    function automatic logic in_rng(input logic [23:0] a,
        input logic [23:0] lo, input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [23:0] mirror(input logic [23:0] a,
        input logic [23:0] base);
        mirror = base | {9'h000, a[sam_pkg::MIRROR_W-1:0]};
    endfunction

    // reset release synchronised; assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // priority chain: specific windows tested before reserved spans
    always_comb begin
        route_d = '0;
        route_d.region = sam_pkg::SAM_RG_NONE;
        route_d.local_addr = acc_addr;
        if (acc_addr >= sam_pkg::IPB_LO) begin
            route_d.region = sam_pkg::SAM_RG_IPB;
        end else if (in_rng(acc_addr, sam_pkg::TRAP_LO, sam_pkg::TRAP_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_TRAP;
        end else if (in_rng(acc_addr, sam_pkg::EPR_LO, sam_pkg::EPR_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_EPR;
            route_d.flash_timing = 1'b1;
            route_d.local_addr = mirror(acc_addr, sam_pkg::EPR_LO);
        end else if (in_rng(acc_addr, sam_pkg::PR_LO, sam_pkg::PR_HI)) begin
            route_d.region = sam_pkg::SAM_RG_PR;
            route_d.local_addr = mirror(acc_addr, sam_pkg::PR_LO);
        end else if (in_rng(acc_addr, sam_pkg::FRES_LO, sam_pkg::FRES_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_FRES;
        end else if (in_rng(acc_addr, sam_pkg::FL3_LO, sam_pkg::FL3_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_FL3;
            route_d.flash_timing = 1'b1;
        end else if (acc_addr >= sam_pkg::FL2_LO
            && acc_addr < sam_pkg::FL3_LO) begin
            route_d.region = sam_pkg::SAM_RG_FL2;
            route_d.flash_timing = 1'b1;
        end else if (acc_addr >= sam_pkg::FL1_LO
            && acc_addr < sam_pkg::FL2_LO) begin
            route_d.region = sam_pkg::SAM_RG_FL1;
            route_d.flash_timing = 1'b1;
        end else if (acc_addr >= sam_pkg::FL0_LO
            && acc_addr < sam_pkg::FL1_LO) begin
            route_d.region = sam_pkg::SAM_RG_FL0;
            route_d.flash_timing = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::EXT_HI_LO,
            sam_pkg::EXT_HI_HI)) begin
            route_d.region = sam_pkg::SAM_RG_EXT;
            route_d.via_ebc = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::EIO_LO, sam_pkg::EIO_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_EIO;
            route_d.via_ebc = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::USA_LO, sam_pkg::USA_HI))
        begin
            // alternate serial view outranks the reserved span it overlaps
            route_d.region = sam_pkg::SAM_RG_US;
            route_d.via_ebc = 1'b1;
            route_d.alt_view = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::PRES_HI_LO,
            sam_pkg::PRES_HI_HI)) begin
            route_d.region = sam_pkg::SAM_RG_PRES;
        end else if (in_rng(acc_addr, sam_pkg::CANA_LO, sam_pkg::CANA_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_CAN;
            route_d.via_ebc = 1'b1;
            route_d.alt_view = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::PRES_LO, sam_pkg::PRES_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_PRES;
        end else if (in_rng(acc_addr, sam_pkg::US_LO, sam_pkg::US_HI)) begin
            route_d.region = sam_pkg::SAM_RG_US;
            route_d.via_ebc = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::CAN_LO, sam_pkg::CAN_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_CAN;
            route_d.via_ebc = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::EXT_LO_LO,
            sam_pkg::EXT_LO_HI)) begin
            route_d.region = sam_pkg::SAM_RG_EXT;
            route_d.via_ebc = 1'b1;
        end else if (in_rng(acc_addr, sam_pkg::SFA_LO, sam_pkg::SFA_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_SFA;
        end else if (in_rng(acc_addr, sam_pkg::DPR_LO, sam_pkg::DPR_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_DPR;
        end else if (in_rng(acc_addr, sam_pkg::DRES_LO, sam_pkg::DRES_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_DRES;
        end else if (in_rng(acc_addr, sam_pkg::ESFA_LO, sam_pkg::ESFA_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_ESFA;
        end else if (in_rng(acc_addr, sam_pkg::XSFA_LO, sam_pkg::XSFA_HI))
        begin
            route_d.region = sam_pkg::SAM_RG_XSFA;
        end
    end

    // gaps (segment 0 below the special areas) fall to region none
    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            route_q <= '0;
            route_valid_q <= 1'b0;
            region_sel_q <= '0;
        end else begin
            route_valid_q <= acc_req;
            if (acc_req) begin
                route_q <= route_d;
                region_sel_q <= 20'h00001 << route_d.region;
            end
        end
    end

    // access trap is hardware trap 0
    always_comb begin
        trap_set = hw_trap;
        if (acc_req && route_d.region == sam_pkg::SAM_RG_TRAP) begin
            trap_set = hw_trap | sam_pkg::TRAP_ACCESS_BIT;
        end
    end

    sam_trap_flags u_flags (
        .clk(ref_clk),
        .rst_sync_b(rst_s_q),
        .trap_set(trap_set),
        .trap_clr(trap_clr),
        .flags_q(trap_flags)
    );

    // higher index means higher priority; level holds the serviced index
    always_comb begin
        top_idx = '0;
        for (int i = 0; i < sam_pkg::TRAP_W; i++) begin
            if (trap_flags[i]) begin
                top_idx = 3'(i);
            end
        end
    end

    assign pend = trap_flags;
    // a trap preempts only when at or above the level in service
    assign trap_take = (|pend) && (!trap_active_q
        || ({1'b0, top_idx} + 4'h1) > {1'b0, trap_level_q});

    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            trap_active_q <= 1'b0;
            trap_level_q <= '0;
        end else if (trap_take) begin
            trap_active_q <= 1'b1;
            trap_level_q <= top_idx;
        end else if (trap_done) begin
            trap_active_q <= 1'b0;
            trap_level_q <= '0;
        end
    end

    // standard and event-controller requests wait out a trap service
    assign std_irq_grant = std_irq_in && !trap_active_q && !trap_take;
    assign pec_grant = pec_req_in && !trap_active_q && !trap_take;

    always_ff @(posedge ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            irq_req_q <= '0;
        end else begin
            irq_req_q <= hw_irq;
            if (sw_req_we) begin
                irq_req_q[sw_req_idx] <= 1'b1;
            end
        end
    end

    a_trap_region_flag: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        acc_req && acc_addr >= sam_pkg::TRAP_LO
        && acc_addr <= sam_pkg::TRAP_HI
        |=> trap_flags[sam_pkg::TRAP_ACCESS_IDX])
        else $error("access trap not flagged");
    a_one_hot_sel: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        route_valid_q |-> $onehot(region_sel_q))
        else $error("region select not one-hot");
    a_ipb_select: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        acc_req && acc_addr >= sam_pkg::IPB_LO
        |=> route_q.region == sam_pkg::SAM_RG_IPB)
        else $error("peripheral space not selected");
    a_mirror_fold: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        acc_req && acc_addr >= sam_pkg::PR_LO && acc_addr <= sam_pkg::EPR_HI
        |=> route_q.local_addr == {$past(acc_addr[23:19]), 4'h0,
            $past(acc_addr[sam_pkg::MIRROR_W-1:0])})
        else $error("mirror not folded");
    a_alt_view_wins: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        acc_req && acc_addr >= sam_pkg::USA_LO && acc_addr <= sam_pkg::USA_HI
        |=> route_q.region == sam_pkg::SAM_RG_US && route_q.alt_view)
        else $error("alternate serial view lost");
    a_flash_timing: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        route_valid_q && route_q.region == sam_pkg::SAM_RG_EPR
        |-> route_q.flash_timing)
        else $error("emulated ram without flash timing");
    a_ebc_route: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        acc_req && acc_addr >= sam_pkg::EXT_HI_LO
        && acc_addr <= sam_pkg::EXT_HI_HI
        |=> route_q.region == sam_pkg::SAM_RG_EXT && route_q.via_ebc)
        else $error("external memory misrouted");
    a_trap_blocks_irq: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        trap_active_q |-> !std_irq_grant && !pec_grant)
        else $error("request granted during trap");
    a_sw_request: assert property (@(posedge ref_clk)
        disable iff (!rst_s_q)
        sw_req_we |=> irq_req_q[$past(sw_req_idx)])
        else $error("software request lost");
endmodule

// File: rtl/sam_pkg.sv
// Purpose: constants and types for the system address map decoder
// Assumes: 24-bit byte addresses, one clock domain
// Notes: region bounds are inclusive start/end pairs, except IPB and FL0-FL2, which give only a start
package sam_pkg;
    localparam int ADDR_W = 24;
    localparam int TRAP_W = 8;
    localparam int IRQ_W = 16;
    localparam int IRQ_IDX_W = 4;
    localparam int MIRROR_W = 15;

    localparam logic [23:0] IPB_LO = 24'hffff00;
    localparam logic [23:0] TRAP_LO = 24'hf00000;
    localparam logic [23:0] TRAP_HI = 24'hfffeff;
    localparam logic [23:0] EPR_LO = 24'he80000;
    localparam logic [23:0] EPR_HI = 24'hefffff;
    localparam logic [23:0] PR_LO = 24'he00000;
    localparam logic [23:0] PR_HI = 24'he7ffff;
    localparam logic [23:0] FRES_LO = 24'hcd0000;
    localparam logic [23:0] FRES_HI = 24'hdfffff;
    localparam logic [23:0] FL0_LO = 24'hc00000;
    localparam logic [23:0] FL1_LO = 24'hc40000;
    localparam logic [23:0] FL2_LO = 24'hc80000;
    localparam logic [23:0] FL3_LO = 24'hcc0000;
    localparam logic [23:0] FL3_HI = 24'hccffff;
    localparam logic [23:0] EXT_HI_LO = 24'h400000;
    localparam logic [23:0] EXT_HI_HI = 24'hbfffff;
    localparam logic [23:0] EIO_LO = 24'h210000;
    localparam logic [23:0] EIO_HI = 24'h3fffff;
    localparam logic [23:0] PRES_HI_LO = 24'h20bc00;
    localparam logic [23:0] PRES_HI_HI = 24'h20ffff;
    localparam logic [23:0] USA_LO = 24'h20b000;
    localparam logic [23:0] USA_HI = 24'h20bfff;
    localparam logic [23:0] CANA_LO = 24'h208000;
    localparam logic [23:0] CANA_HI = 24'h20afff;
    localparam logic [23:0] PRES_LO = 24'h206000;
    localparam logic [23:0] PRES_HI = 24'h207fff;
    localparam logic [23:0] US_LO = 24'h204000;
    localparam logic [23:0] US_HI = 24'h205fff;
    localparam logic [23:0] CAN_LO = 24'h200000;
    localparam logic [23:0] CAN_HI = 24'h203fff;
    localparam logic [23:0] EXT_LO_LO = 24'h010000;
    localparam logic [23:0] EXT_LO_HI = 24'h1fffff;
    localparam logic [23:0] SFA_LO = 24'h00fe00;
    localparam logic [23:0] SFA_HI = 24'h00ffff;
    localparam logic [23:0] DPR_LO = 24'h00f600;
    localparam logic [23:0] DPR_HI = 24'h00fdff;
    localparam logic [23:0] DRES_LO = 24'h00f200;
    localparam logic [23:0] DRES_HI = 24'h00f5ff;
    localparam logic [23:0] ESFA_LO = 24'h00f000;
    localparam logic [23:0] ESFA_HI = 24'h00f1ff;
    localparam logic [23:0] XSFA_LO = 24'h00e000;
    localparam logic [23:0] XSFA_HI = 24'h00efff;

    localparam logic [7:0] TRAP_ACCESS_BIT = 8'h01;
    localparam logic [2:0] TRAP_ACCESS_IDX = 3'h0;

    typedef enum logic [4:0] {
        SAM_RG_NONE, SAM_RG_IPB, SAM_RG_TRAP, SAM_RG_EPR, SAM_RG_PR,
        SAM_RG_FRES, SAM_RG_FL0, SAM_RG_FL1, SAM_RG_FL2, SAM_RG_FL3,
        SAM_RG_EXT, SAM_RG_EIO, SAM_RG_US, SAM_RG_CAN, SAM_RG_PRES,
        SAM_RG_SFA, SAM_RG_ESFA, SAM_RG_XSFA, SAM_RG_DPR, SAM_RG_DRES
    } sam_region_e;

    typedef struct packed {
        sam_region_e region;
        logic [23:0] local_addr;
        logic via_ebc;
        logic flash_timing;
        logic alt_view;
    } sam_route_s;
endpackage

// File: rtl/sam_trap_flags.sv
// Purpose: trap flag register, one sticky bit per hardware trap
// Assumes: trap pulses and clear masks come from the same clock
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module sam_trap_flags (
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic [sam_pkg::TRAP_W-1:0] trap_set,
    input wire logic [sam_pkg::TRAP_W-1:0] trap_clr,
    output logic [sam_pkg::TRAP_W-1:0] flags_q
);
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~trap_clr) | trap_set;
        end
    end

    a_flag_set_holds: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        |trap_set |-> ##1 ((flags_q & $past(trap_set)) == $past(trap_set)))
        else $error("trap flag not set");
endmodule

// File: tb/sam_core_model.sv
// Purpose: processor core model issuing accesses to the decoder
// Assumes: at most one access per cycle, driven on the falling edge
// Notes: a released address bus shows its previous value inverted, so every second idle shows the last access again
`timescale 1ns/1ps
module sam_core_model (
    input wire logic ref_clk,
    output logic acc_req,
    output logic [23:0] acc_addr
);
    initial begin
        acc_req = 1'b0;
        acc_addr = 24'h000000;
    end

    task automatic issue(input logic [23:0] a);
        @(negedge ref_clk);
        acc_req = 1'b1;
        acc_addr = a;
    endtask

    // stale address would hide a decoder that ignores acc_req
    task automatic idle();
        @(negedge ref_clk);
        acc_req = 1'b0;
        acc_addr = ~acc_addr;
    endtask
endmodule

// File: tb/system_address_map_decoder_tb.sv
// Purpose: self-checking bench for the address map decoder
// Assumes: 10 MHz ref_clk, inputs change on the falling edge
// Notes: routes are checked through a queue of expected notes
`timescale 1ns/1ps
module system_address_map_decoder_tb;
    typedef struct packed {
        logic [23:0] a;
        sam_pkg::sam_region_e r;
    } sam_note_s;
    localparam logic [23:0] PROBES [55] = '{
        24'hffff00, 24'hffffff, 24'hf00000, 24'hfffeff,
        24'he80000, 24'he87fff, 24'he88000, 24'hefffff,
        24'he00000, 24'he07fff, 24'he08000, 24'he7ffff, 24'he09234,
        24'hc00000, 24'hc3ffff, 24'hc40000, 24'hc7ffff,
        24'hc80000, 24'hcbffff, 24'hcc0000, 24'hccffff,
        24'hcd0000, 24'hdfffff, 24'h400000, 24'hbfffff,
        24'h010000, 24'h1fffff, 24'h210000, 24'h3fffff,
        24'h204000, 24'h205fff, 24'h20b000, 24'h20bbff,
        24'h200000, 24'h203fff, 24'h208000, 24'h20afff,
        24'h206000, 24'h207fff, 24'h20bc00, 24'h20ffff,
        24'h00fe00, 24'h00ffff, 24'h00f000, 24'h00f1ff,
        24'h00e000, 24'h00efff, 24'h00f600, 24'h00fdff,
        24'h00f200, 24'h00f5ff, 24'h00dfff, 24'h000000, 24'h00ffff,
        24'h20bfff
    };
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic acc_req;
    logic [23:0] acc_addr;
    logic [7:0] hw_trap = 8'h00;
    logic [7:0] trap_clr = 8'h00;
    logic trap_done = 1'b0;
    logic [15:0] hw_irq = 16'h0000;
    logic sw_req_we = 1'b0;
    logic [3:0] sw_req_idx = 4'h0;
    logic std_irq_in = 1'b0;
    logic pec_req_in = 1'b0;
    sam_pkg::sam_route_s route_q;
    logic route_valid_q;
    logic [19:0] region_sel_q;
    logic [7:0] trap_flags;
    logic trap_take;
    logic [2:0] trap_level_q;
    logic trap_active_q;
    logic [15:0] irq_req_q;
    logic std_irq_grant;
    logic pec_grant;
    int fails = 0;
    int n_compared = 0;
    logic [15:0] seed = 16'h0002;
    logic [23:0] ra;
    logic [7:0] acc_flags;
    sam_note_s cur;
    logic [23:0] exp_la;
    sam_note_s notes[$];

    sam_core_model sam_core_model_inst (.ref_clk(ref_clk),
        .acc_req(acc_req), .acc_addr(acc_addr));
    sam_decoder sam_decoder_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .acc_req(acc_req), .acc_addr(acc_addr), .hw_trap(hw_trap),
        .trap_clr(trap_clr), .trap_done(trap_done), .hw_irq(hw_irq),
        .sw_req_we(sw_req_we), .sw_req_idx(sw_req_idx),
        .std_irq_in(std_irq_in), .pec_req_in(pec_req_in),
        .route_q(route_q), .route_valid_q(route_valid_q),
        .region_sel_q(region_sel_q), .trap_flags(trap_flags),
        .trap_take(trap_take), .trap_level_q(trap_level_q),
        .trap_active_q(trap_active_q), .irq_req_q(irq_req_q),
        .std_irq_grant(std_irq_grant), .pec_grant(pec_grant));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // priority order lets the specific windows win over wide ranges
    function automatic sam_pkg::sam_region_e exp_rg(input logic [23:0] a);
        if (a >= 24'hffff00) return sam_pkg::SAM_RG_IPB;
        if (a >= 24'hf00000) return sam_pkg::SAM_RG_TRAP;
        if (a >= 24'he80000) return sam_pkg::SAM_RG_EPR;
        if (a >= 24'he00000) return sam_pkg::SAM_RG_PR;
        if (a >= 24'hcd0000) return sam_pkg::SAM_RG_FRES;
        if (a >= 24'hcc0000) return sam_pkg::SAM_RG_FL3;
        if (a >= 24'hc80000) return sam_pkg::SAM_RG_FL2;
        if (a >= 24'hc40000) return sam_pkg::SAM_RG_FL1;
        if (a >= 24'hc00000) return sam_pkg::SAM_RG_FL0;
        if (a >= 24'h400000) return sam_pkg::SAM_RG_EXT;
        if (a >= 24'h210000) return sam_pkg::SAM_RG_EIO;
        // alternate serial view outranks the reserved span it overlaps
        if (a >= 24'h20c000) return sam_pkg::SAM_RG_PRES;
        if (a >= 24'h20b000) return sam_pkg::SAM_RG_US;
        if (a >= 24'h208000) return sam_pkg::SAM_RG_CAN;
        if (a >= 24'h206000) return sam_pkg::SAM_RG_PRES;
        if (a >= 24'h204000) return sam_pkg::SAM_RG_US;
        if (a >= 24'h200000) return sam_pkg::SAM_RG_CAN;
        if (a >= 24'h010000) return sam_pkg::SAM_RG_EXT;
        if (a >= 24'h00fe00) return sam_pkg::SAM_RG_SFA;
        if (a >= 24'h00f600) return sam_pkg::SAM_RG_DPR;
        if (a >= 24'h00f200) return sam_pkg::SAM_RG_DRES;
        if (a >= 24'h00f000) return sam_pkg::SAM_RG_ESFA;
        if (a >= 24'h00e000) return sam_pkg::SAM_RG_XSFA;
        return sam_pkg::SAM_RG_NONE;
    endfunction

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [23:0] a);
        notes.push_back('{a, exp_rg(a)});
        sam_core_model_inst.issue(a);
    endtask

    task automatic trap_step(input logic [7:0] set, input logic [7:0] clr,
                             input logic done);
        @(negedge ref_clk);
        hw_trap = set;
        trap_clr = clr;
        trap_done = done;
        @(negedge ref_clk);
        hw_trap = 8'h00;
        trap_clr = 8'h00;
        trap_done = 1'b0;
        #1;
    endtask

    task automatic final_report();
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(negedge ref_clk) begin
        if (route_valid_q === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk("region", 24'(cur.r), 24'(route_q.region));
            chk("one hot", 24'(20'h1 << cur.r), 24'(region_sel_q));
            exp_la = cur.a;
            if (cur.r inside {sam_pkg::SAM_RG_PR, sam_pkg::SAM_RG_EPR})
                exp_la = {cur.a[23:19], 4'h0, cur.a[14:0]};
            chk("mirror", exp_la, route_q.local_addr);
            chk("flash timing", 24'(cur.r inside {sam_pkg::SAM_RG_EPR,
                sam_pkg::SAM_RG_FL0, sam_pkg::SAM_RG_FL1, sam_pkg::SAM_RG_FL2,
                sam_pkg::SAM_RG_FL3}), 24'(route_q.flash_timing));
            chk("bus ctrl", 24'(cur.r inside {sam_pkg::SAM_RG_EXT,
                sam_pkg::SAM_RG_EIO, sam_pkg::SAM_RG_US,
                sam_pkg::SAM_RG_CAN}), 24'(route_q.via_ebc));
            chk("alt view", 24'(cur.r inside {sam_pkg::SAM_RG_US,
                sam_pkg::SAM_RG_CAN} && cur.a >= 24'h208000),
                24'(route_q.alt_view));
        end else if (route_valid_q === 1'b1) begin
            chk("extra route", 24'h0, 24'h1);
        end
    end

    initial begin
        #2000000;
        fails++;
        final_report();
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        foreach (PROBES[i]) send(PROBES[i]);
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            ra[23:8] = seed;
            seed = lfsr(seed);
            ra[7:0] = seed[7:0];
            send(ra);
        end
        sam_core_model_inst.idle();
        repeat (3) sam_core_model_inst.idle();
        chk("notes left", 24'h0, 24'(notes.size()));
        acc_flags = trap_flags;
        chk("access trap", 24'h1, 24'(acc_flags));
        trap_step(8'h00, 8'hff, 1'b0);
        trap_step(8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 8; i++) begin
            trap_step(8'h1 << i, 8'h00, 1'b0);
            chk("trap flags", 24'((16'h2 << i) - 16'h1), 24'(trap_flags));
        end
        trap_step(8'h00, 8'hff, 1'b0);
        trap_step(8'h00, 8'h00, 1'b1);
        std_irq_in = 1'b1;
        pec_req_in = 1'b1;
        trap_step(8'h04, 8'h00, 1'b0);
        chk("take idle", 24'h1, 24'(trap_take));
        trap_step(8'h00, 8'h00, 1'b0);
        chk("level", 24'h2, 24'(trap_level_q));
        chk("std blocked", 24'h0, 24'(std_irq_grant));
        chk("pec blocked", 24'h0, 24'(pec_grant));
        trap_step(8'h00, 8'hff, 1'b0);
        trap_step(8'h02, 8'h00, 1'b0);
        chk("take lower", 24'h0, 24'(trap_take));
        trap_step(8'h20, 8'h00, 1'b0);
        chk("take higher", 24'h1, 24'(trap_take));
        trap_step(8'h00, 8'hff, 1'b0);
        trap_step(8'h00, 8'h00, 1'b1);
        chk("active", 24'h0, 24'(trap_active_q));
        chk("std grant", 24'h1, 24'(std_irq_grant));
        chk("pec grant", 24'h1, 24'(pec_grant));
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            @(negedge ref_clk);
            // keep the software bit out of the copy so only the write sets it
            hw_irq = seed & ~(16'h0001 << i);
            sw_req_we = 1'b1;
            sw_req_idx = 4'(i);
            @(negedge ref_clk);
            sw_req_we = 1'b0;
            chk("sw request", 24'h1, 24'(irq_req_q[i]));
            chk("hw request", 24'(hw_irq | (16'h0001 << i)),
                24'(irq_req_q));
        end
        final_report();
    end
endmodule
